/* rtl/brake_defs.svh */
// Constants of the brake configuration register bank
`ifndef BRAKE_DEFS_SVH
`define BRAKE_DEFS_SVH

// Register address on the serial register port
`define BRK_ADDR 7'h1d

// Reset values and bit masks
`define BRK_RESET 16'h00a0
`define BRK_WR_MASK 16'h1fff
`define BRK_RESTART_KEEP 16'h1fe7

// Field positions
`define BRK_POS_LS3_EXCL 12
`define BRK_POS_LS2_EXCL 11
`define BRK_POS_LS1_EXCL 10
`define BRK_POS_ALL_LS 9
`define BRK_POS_VDS_SEL 8
`define BRK_POS_BLANK_SEL 7
`define BRK_POS_PARK_EN 6
`define BRK_POS_OV_EN 5

// Overvoltage threshold base, code zero, in volts
`define BRK_OV_BASE_V 6'h1b

// Timing: clock period and blanking intervals in ns
`define BRK_CLK_NS 25
`define BRK_BLK_SHORT_NS 7000
`define BRK_BLK_LONG_NS 11000
`define BRK_BLK_SHORT_CYC \
    ((`BRK_BLK_SHORT_NS + `BRK_CLK_NS - 1) / `BRK_CLK_NS)
`define BRK_BLK_LONG_CYC \
    ((`BRK_BLK_LONG_NS + `BRK_CLK_NS - 1) / `BRK_CLK_NS)

`endif

/* rtl/brake_pkg.sv */
// Types of the brake configuration register bank
`default_nettype none

package brake_pkg;

    // Register image, bit 15 first
    typedef struct packed {
        logic [2:0] reserved_hi;
        logic       lowside3_brake_exclude;
        logic       lowside2_brake_exclude;
        logic       lowside1_brake_exclude;
        logic       all_lowside_brake;
        logic       brake_drain_source_threshold_sel;
        logic       brake_blanking_time_sel;
        logic       parking_brake_enable;
        logic       overvoltage_brake_enable;
        logic [1:0] reserved_lo;
        logic [2:0] overvoltage_brake_threshold;
    } brake_cfg_t;

    // Blanking sequencer, one bit per step except BLK_ARMED to BLK_IDLE
    typedef enum logic [1:0] {
        BLK_IDLE  = 2'b00,
        BLK_WAIT  = 2'b01,
        BLK_ARMED = 2'b11
    } blank_state_t;

endpackage

`default_nettype wire

/* rtl/motor_brake_control_register.sv */
// Brake configuration register and low-side brake control
// Notes on behaviour
// - Bits 15 to 13 are reserved, never stored, always read zero.
// - Bit 9 turns all-low-side braking on; off after reset.
// - Bits 12, 11, 10 keep low-side 3, 2, 1 out of braking.
// - Bit 8 picks the braking drain-source limit: 0.8 V or 0.22 V.
// - Bit 7 picks braking blanking: about 7 us or 11 us (default).
// - Bit 6 enables the parking brake; off after reset.
// - Bit 5 enables the supply overvoltage brake; on after reset.
// - Bits 2 to 0 set the brake supply level, 27 V plus code.
// - Power-on or soft reset loads 0x00a0.
// - Restart clears bits 15 to 13 and 4 to 3, keeps the rest.
`include "brake_defs.svh"
`default_nettype none

module motor_brake_control_register #(
    parameter int unsigned BLK_SHORT_CYC = `BRK_BLK_SHORT_CYC,
    parameter int unsigned BLK_LONG_CYC  = `BRK_BLK_LONG_CYC,
    parameter int unsigned CNT_W         = 9
) (
    // Clock, reset and clock enable
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                ce,
    // Reset requests from the supervisor, one-cycle pulses
    input  wire logic                soft_reset,
    input  wire logic                restart,
    // Register port from the serial frame decoder
    input  wire logic [6:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic [15:0]         reg_wdata,
    output logic [15:0]              reg_rdata,
    // Analog monitor results, asynchronous
    input  wire logic [5:0]          supply_volts,
    input  wire logic [2:0]          vds_over,
    // Configuration to the gate-control logic
    output brake_pkg::brake_cfg_t    brake_cfg,
    // Low-side gate commands and fault flag
    output logic                     lowside_output_1,
    output logic                     lowside_output_2,
    output logic                     lowside_output_3,
    output logic                     drain_source_fault
);
    import brake_pkg::*;

    // Refuse counts the blanking counter cannot hold
    if (BLK_SHORT_CYC < 1 || BLK_LONG_CYC < 1 ||
        BLK_SHORT_CYC >= (1 << CNT_W) ||
        BLK_LONG_CYC >= (1 << CNT_W)) begin : g_chk
        $error("Blanking counts do not fit the counter");
    end

    localparam logic [CNT_W-1:0] SHORT_LIM = CNT_W'(BLK_SHORT_CYC);
    localparam logic [CNT_W-1:0] LONG_LIM  = CNT_W'(BLK_LONG_CYC);

    // Threshold in volts for a 3-bit code
    function automatic logic [5:0] ov_level(input logic [2:0] code);
        return `BRK_OV_BASE_V + {3'h0, code};
    endfunction

    brake_cfg_t       cfg_q;
    brake_cfg_t       cfg_d;
    logic [15:0]      rdata_q;
    logic [15:0]      rdata_d;
    logic [5:0]       sup_m_q;
    logic [5:0]       sup_s_q;
    logic [2:0]       vds_m_q;
    logic [2:0]       vds_s_q;
    logic             ov_trip_q;
    logic             ov_trip_d;
    logic [2:0]       ls_on_q;
    logic [2:0]       ls_on_d;
    logic             fault_q;
    logic             fault_d;
    blank_state_t     st_q;
    blank_state_t     st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] lim_q;
    logic [CNT_W-1:0] lim_d;

    // Address decode and write qualification
    wire        addr_hit  = reg_addr == `BRK_ADDR;
    wire        wr_hit    = reg_wr && addr_hit;
    wire [15:0] restarted = cfg_q & `BRK_RESTART_KEEP;
    wire [15:0] written   = reg_wdata & `BRK_WR_MASK;

    assign cfg_d = soft_reset ? brake_cfg_t'(`BRK_RESET) :
                   restart    ? brake_cfg_t'(restarted) :
                   wr_hit     ? brake_cfg_t'(written) : cfg_q;

    // read answers only at its address
    assign rdata_d = addr_hit ? (cfg_q & `BRK_WR_MASK) : 16'h0000;

    // Configuration register and read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q   <= brake_cfg_t'(`BRK_RESET);
            rdata_q <= 16'h0000;
        end else if (ce) begin
            cfg_q   <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // Two-stage synchronisers for the monitor pins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sup_m_q <= 6'h00;
            sup_s_q <= 6'h00;
            vds_m_q <= 3'h0;
            vds_s_q <= 3'h0;
        end else if (ce) begin
            sup_m_q <= supply_volts;
            sup_s_q <= sup_m_q;
            vds_m_q <= vds_over;
            vds_s_q <= vds_m_q;
        end
    end

    assign ov_trip_d = cfg_q.overvoltage_brake_enable &&
        (sup_s_q > ov_level(cfg_q.overvoltage_brake_threshold));

    wire brake_req = cfg_q.all_lowside_brake || ov_trip_q;
    wire [2:0] excl = {cfg_q.lowside3_brake_exclude,
                       cfg_q.lowside2_brake_exclude,
                       cfg_q.lowside1_brake_exclude};
    assign ls_on_d = {3{brake_req}} & ~excl;

    // Brake path registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ov_trip_q <= 1'b0;
            ls_on_q   <= 3'h0;
            fault_q   <= 1'b0;
        end else if (ce) begin
            ov_trip_q <= ov_trip_d;
            ls_on_q   <= ls_on_d;
            fault_q   <= fault_d;
        end
    end

    wire [CNT_W-1:0] sel_lim =
        cfg_q.brake_blanking_time_sel ? LONG_LIM : SHORT_LIM;
    wire any_on   = |ls_on_q;
    wire cnt_done = cnt_q == lim_q - CNT_W'(1);
    wire turn_on  = |(ls_on_d & ~ls_on_q);

    // Blanking sequencer next state
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        lim_d = lim_q;
        unique case (st_q)
            BLK_IDLE: begin
                if (any_on) begin
                    st_d  = BLK_WAIT;
                    cnt_d = '0;
                    lim_d = sel_lim;
                end
            end
            BLK_WAIT: begin
                if (!any_on || turn_on) begin
                    st_d = BLK_IDLE;
                end else if (cnt_done) begin
                    st_d = BLK_ARMED;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            BLK_ARMED: begin
                if (!any_on || turn_on) begin
                    st_d = BLK_IDLE;
                end
            end
            default: begin
                st_d = BLK_IDLE;
            end
        endcase
    end

    // Blanking sequencer registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q  <= BLK_IDLE;
            cnt_q <= '0;
            lim_q <= '0;
        end else if (ce) begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            lim_q <= lim_d;
        end
    end

    assign fault_d = st_q == BLK_ARMED && !turn_on &&
        |(vds_s_q & ls_on_q);

    // outputs: configuration, read data, low-side gates and fault flag
    assign brake_cfg          = cfg_q;
    assign reg_rdata          = rdata_q;
    assign lowside_output_1   = ls_on_q[0];
    assign lowside_output_2   = ls_on_q[1];
    assign lowside_output_3   = ls_on_q[2];
    assign drain_source_fault = fault_q;

    // Checks on the register and the brake path
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_restart;
        ce && restart && !soft_reset;
    endsequence

    sequence s_write;
        ce && wr_hit && !restart && !soft_reset;
    endsequence

    property p_rsvd_zero;
        reg_rdata[15:13] == 3'h0 && cfg_q.reserved_hi == 3'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("Reserved top bits not zero");

    property p_write_modes;
        s_write |=> cfg_q.all_lowside_brake ==
                $past(reg_wdata[`BRK_POS_ALL_LS]) &&
            cfg_q.parking_brake_enable ==
                $past(reg_wdata[`BRK_POS_PARK_EN]) &&
            cfg_q.brake_drain_source_threshold_sel ==
                $past(reg_wdata[`BRK_POS_VDS_SEL]);
    endproperty
    a_write_modes: assert property (p_write_modes)
        else $error("Mode bits not written");

    property p_exclude;
        ce |=> (ls_on_q & $past(excl)) == 3'h0;
    endproperty
    a_exclude: assert property (p_exclude)
        else $error("Excluded low side switched on");

    property p_blank;
        ce && st_q == BLK_WAIT && cnt_done && any_on && !turn_on
            |=> st_q == BLK_ARMED ##0
                $past(cnt_q) == lim_q - CNT_W'(1);
    endproperty
    a_blank: assert property (p_blank)
        else $error("Blanking did not end at its count");

    property p_lim_sel;
        ce && st_q == BLK_IDLE && any_on |=>
            lim_q == ($past(cfg_q.brake_blanking_time_sel) ?
                      LONG_LIM : SHORT_LIM);
    endproperty
    a_lim_sel: assert property (p_lim_sel)
        else $error("Wrong blanking length chosen");

    property p_ov_trip;
        ce && cfg_q.overvoltage_brake_enable &&
            sup_s_q > ov_level(cfg_q.overvoltage_brake_threshold)
            |=> ov_trip_q ##1 (!$past(ce) || ls_on_q == ~$past(excl, 1));
    endproperty
    a_ov_trip: assert property (p_ov_trip)
        else $error("Overvoltage brake not applied");

    property p_soft;
        ce && soft_reset |=> cfg_q == brake_cfg_t'(`BRK_RESET);
    endproperty
    a_soft: assert property (p_soft)
        else $error("Soft reset value wrong");

    property p_restart;
        s_restart |=> cfg_q == brake_cfg_t'($past(restarted));
    endproperty
    a_restart: assert property (p_restart)
        else $error("Restart value wrong");

    property p_read;
        ce && !addr_hit |=> reg_rdata == 16'h0000;
    endproperty
    a_read: assert property (p_read)
        else $error("Read data outside the register address");

    property p_release;
        ce && !brake_req |=> ls_on_q == 3'h0;
    endproperty
    a_release: assert property (p_release)
        else $error("Low side on without brake request");

    property p_fault;
        drain_source_fault |-> $past(st_q) == BLK_ARMED;
    endproperty
    a_fault: assert property (p_fault)
        else $error("Fault flagged inside blanking");

endmodule

`default_nettype wire

/* test/brake_fet_model.sv */
// Behavioural model of the three external low-side MOSFETs
`default_nettype none

module brake_fet_model (
    // Gate commands from the block
    input  wire logic [2:0] gate_on,
    // Bench command: the FET that is on sees a shorted load
    input  wire logic [2:0] short_cmd,
    // Drain-source comparator outputs, bit 0 for low side 1
    output logic      [2:0] vds_over
);
    timeunit 1ns;
    timeprecision 1ps;

    // An off FET blocks the supply, so its comparator reads high
    assign vds_over = ~gate_on | short_cmd;
endmodule

`default_nettype wire

/* test/test_motor_brake_control_register.sv */
// Self-checking bench of the brake configuration register bank
`include "brake_defs.svh"
`default_nettype none

module test_motor_brake_control_register;
    timeunit 1ns;
    timeprecision 1ps;
    import brake_pkg::*;

    localparam int unsigned SHORT = 3;
    localparam int unsigned LONG  = 5;

    logic             clk = 1'b0;
    logic             reset_n;
    logic             ce;
    logic             soft_reset;
    logic             restart;
    logic [6:0]       reg_addr;
    logic             reg_wr;
    logic [15:0]      reg_wdata;
    logic [15:0]      reg_rdata;
    logic [5:0]       supply_volts;
    logic [2:0]       vds_over;
    logic [2:0]       short_cmd;
    brake_cfg_t       brake_cfg;
    logic             ls1;
    logic             ls2;
    logic             ls3;
    logic             fault;
    wire  [2:0]       ls = {ls3, ls2, ls1};
    int               n_errors = 0;
    int               checks = 0;

    // Clock at 40 MHz
    always #12.5 clk = ~clk;

    motor_brake_control_register #(
        .BLK_SHORT_CYC(SHORT),
        .BLK_LONG_CYC (LONG),
        .CNT_W        (9)
    ) u_dut (
        .clk               (clk),
        .reset_n           (reset_n),
        .ce                (ce),
        .soft_reset        (soft_reset),
        .restart           (restart),
        .reg_addr          (reg_addr),
        .reg_wr            (reg_wr),
        .reg_wdata         (reg_wdata),
        .reg_rdata         (reg_rdata),
        .supply_volts      (supply_volts),
        .vds_over          (vds_over),
        .brake_cfg         (brake_cfg),
        .lowside_output_1  (ls1),
        .lowside_output_2  (ls2),
        .lowside_output_3  (ls3),
        .drain_source_fault(fault)
    );

    brake_fet_model u_fet (
        .gate_on  (ls),
        .short_cmd(short_cmd),
        .vds_over (vds_over)
    );

    task automatic stop_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One write strobe, address back on the register afterwards
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d & 16'hffe7;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = `BRK_ADDR;
    endtask

    task automatic rd(input logic [15:0] exp);
        repeat (2) @(negedge clk);
        chk(reg_rdata, exp);
    endtask

    task automatic t_reset();
        chk(brake_cfg, 16'h00a0);
        rd(16'h00a0);
        chk({12'h0, ls, fault}, 16'h0000);
    endtask

    task automatic t_regs();
        wr(`BRK_ADDR, 16'hffe7);
        rd(16'h1fe7);
        chk({15'h0, brake_cfg.parking_brake_enable}, 16'h0001);
        chk({13'h0, brake_cfg.overvoltage_brake_threshold}, 16'h7);
        wr(7'h1c, 16'h0143);
        rd(16'h1fe7);
        reg_addr = 7'h1c;
        rd(16'h0000);
        reg_addr = `BRK_ADDR;
        ce = 1'b0;
        wr(`BRK_ADDR, 16'h0000);
        ce = 1'b1;
        rd(16'h1fe7);
        wr(`BRK_ADDR, 16'h0000);
        rd(16'h0000);
    endtask

    task automatic t_slam();
        for (int m = 0; m < 8; m++) begin
            wr(`BRK_ADDR, 16'h0200 | 16'(m << 10));
            repeat (2) @(negedge clk);
            chk({13'h0, ls}, {13'h0, ~m[2:0]});
        end
        wr(`BRK_ADDR, 16'h0000);
        repeat (2) @(negedge clk);
        chk({13'h0, ls}, 16'h0000);
    endtask

    // Supply just at and just above each threshold code
    task automatic t_ovbrake();
        for (int c = 0; c < 8; c++) begin
            wr(`BRK_ADDR, 16'h0020 | 16'(c));
            supply_volts = 6'(27 + c);
            repeat (6) @(negedge clk);
            chk({13'h0, ls}, 16'h0000);
            supply_volts = 6'(28 + c);
            repeat (6) @(negedge clk);
            chk({12'h0, ls, fault}, 16'h000e);
            supply_volts = 6'h00;
            repeat (6) @(negedge clk);
            chk({13'h0, ls}, 16'h0000);
        end
        wr(`BRK_ADDR, 16'h0820);
        supply_volts = 6'h1e;
        repeat (6) @(negedge clk);
        chk({13'h0, ls}, 16'h0005);
        wr(`BRK_ADDR, 16'h0000);
        repeat (6) @(negedge clk);
        chk({13'h0, ls}, 16'h0000);
        supply_volts = 6'h00;
        repeat (6) @(negedge clk);
    endtask

    // Shorted loads: fault only once blanking has run out
    task automatic t_blank(input logic long);
        int lim;
        int n;
        lim = long ? LONG : SHORT;
        short_cmd = 3'b111;
        wr(`BRK_ADDR, long ? 16'h0280 : 16'h0200);
        for (n = 0; n < 8 && ls1 !== 1'b1; n++) @(negedge clk);
        if (ls1 !== 1'b1) begin
            n_errors++;
            $display("BAD %0t low side never on", $time);
            stop_test();
        end
        for (n = 0; n < 30 && fault !== 1'b1; n++) @(negedge clk);
        chk({15'h0, n > lim && n <= lim + 3}, 16'h0001);
        short_cmd = 3'b000;
        repeat (4) @(negedge clk);
        chk({15'h0, fault}, 16'h0000);
        wr(`BRK_ADDR, 16'h0000);
        repeat (3) @(negedge clk);
    endtask

    task automatic t_resets();
        wr(`BRK_ADDR, 16'h1de5);
        @(negedge clk);
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        rd(16'h1de5);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        rd(16'h00a0);
        wr(`BRK_ADDR, 16'h1de5);
        @(negedge clk);
        soft_reset = 1'b1;
        restart    = 1'b1;
        reg_wr     = 1'b1;
        reg_wdata  = 16'h0143;
        @(negedge clk);
        {soft_reset, restart, reg_wr} = 3'b000;
        rd(16'h00a0);
        wr(`BRK_ADDR, 16'h0143);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        chk(brake_cfg, 16'h00a0);
        reset_n = 1'b1;
    endtask

    // Main sequence
    initial begin
        {ce, soft_reset, restart, reg_wr} = 4'b1000;
        reg_addr     = `BRK_ADDR;
        reg_wdata    = 16'h0000;
        supply_volts = 6'h00;
        short_cmd    = 3'b000;
        reset_n      = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        t_reset();
        t_regs();
        t_slam();
        t_ovbrake();
        t_blank(1'b0);
        t_blank(1'b1);
        t_resets();
        stop_test();
    end
endmodule

`default_nettype wire
